//--- hdl/sicc_consts.svh
// Register offsets, field positions and reset values of the status and startup block.
`ifndef SICC_CONSTS_SVH
`define SICC_CONSTS_SVH
`define SICC_ADDR_NOW      8'h00
`define SICC_ADDR_STICKY   8'h04
`define SICC_ADDR_IRQ_EN   8'h08
`define SICC_ADDR_CTRL     8'h0c
`define SICC_NOW_W         8
`define SICC_STICKY_W      6
`define SICC_NOW_REF       7
`define SICC_NOW_SEL       6
`define SICC_NOW_CAL       5
`define SICC_STK_IN0       0
`define SICC_STK_IN1       1
`define SICC_STK_VCXO      2
`define SICC_STK_SYNTH     3
`define SICC_STK_HOLD      4
`define SICC_STK_REF       5
`define SICC_CTRL_INIT     0
`define SICC_CTRL_PLL_TRIGGER_A   1
`define SICC_CTRL_CAL      2
`define SICC_CTRL_FORCE    3
`define SICC_CTRL_BANK     4
`define SICC_CTRL_RST      5'h08
`define SICC_IRQ_EN_RST    6'h00
`define SICC_FAULT_RST     6'h00
`endif

//--- hdl/sicc_pkg.sv
// Types shared by the status and startup block.
package sicc_pkg;
    typedef enum logic [1:0] {
        SICC_MODE_MANUAL,
        SICC_MODE_AUTO,
        SICC_MODE_MAN_HOLD,
        SICC_MODE_AUTO_HOLD
    } sicc_mode_t;

    typedef struct packed {
        logic       in0_act;
        logic       in1_act;
        logic       vcxo_lock;
        logic       synth_lock;
        logic       holdover;
        logic       cal_done;
        logic       sel;
        logic       selecting;
        sicc_mode_t mode;
    } sicc_pins_t;

    typedef struct packed {
        logic bank_en;
        logic force_center;
        logic cal;
        logic pll_trigger_a;
        logic init;
    } sicc_ctrl_t;
endpackage

//--- hdl/sicc_top.sv
// Status latching, interrupt, lock output and startup control bits behind a Wishbone slave.
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "sicc_consts.svh"

// Behaviour
// - momentary status reads live, read-only
// - six sticky bits; calibration and selection none
// - sticky sets on condition, stays until write-1
// - clear fails while condition still present
// - per-bit enable masks sticky from interrupt
// - interrupt held until all enabled sources cleared
// - lock and clock bits read 1 good
// - calibration done bit; holdover bits 0 inside
// - manual mode: reference valid follows selected input
// - automatic mode: invalid while lost or selecting
// - manual holdover: invalid after change during holdover
// - auto holdover: invalid while lost or in holdover
// - lock output high only both PLLs locked
// - reset returns every register to default
// - VCXO control centred until force bit cleared
// - bank outputs disabled until software enables
// - init bit starts sync then self-clears
// - pll_trigger_a and calibration bits self-clear
module sicc_top (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire sicc_pkg::sicc_pins_t pins_i,
    output sicc_pkg::sicc_ctrl_t   ctrl_o,
    output logic                   irq_out_n_o,
    output logic                   lock_o
);
    import sicc_pkg::*;

    // Analogue monitors live outside this clock; two stages before any use.
    sicc_pins_t pins_meta;
    sicc_pins_t pins_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_meta <= '0;
            pins_s    <= '0;
        end else begin
            pins_meta <= pins_i;
            pins_s    <= pins_meta;
        end
    end

    // Bus access decode.
    logic req;
    logic wr_now;
    logic wr_byte;

    assign req     = wb_cyc_i & wb_stb_i;
    assign wr_now  = req & wb_ack_o & wb_we_i;
    assign wr_byte = wr_now & wb_sel_i[0];

    // Manual change tracking for the manual holdover mode.
    logic sel_prev;
    logic man_chg;
    logic next_sel_prev;
    logic next_man_chg;

    always_comb begin
        next_sel_prev = pins_s.sel;
        next_man_chg  = 1'b0;
        if (pins_s.holdover) begin
            next_man_chg = man_chg | (pins_s.sel != sel_prev);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_prev <= 1'b0;
            man_chg  <= 1'b0;
        end else begin
            sel_prev <= next_sel_prev;
            man_chg  <= next_man_chg;
        end
    end

    // Reference validity depends on the selection mode.
    logic sel_act;
    logic ref_valid;

    assign sel_act = pins_s.sel ? pins_s.in1_act : pins_s.in0_act;

    always_comb begin
        case (pins_s.mode)
            SICC_MODE_MANUAL: begin
                ref_valid = sel_act;
            end
            SICC_MODE_AUTO: begin
                ref_valid = sel_act & ~pins_s.selecting;
            end
            SICC_MODE_MAN_HOLD: begin
                ref_valid = sel_act & ~(man_chg & pins_s.holdover);
            end
            SICC_MODE_AUTO_HOLD: begin
                ref_valid = sel_act & ~pins_s.holdover;
            end
            default: begin
                ref_valid = sel_act;
            end
        endcase
    end

    // Momentary view; every good state reads as 1.
    logic [`SICC_NOW_W-1:0] now_vec;

    assign now_vec = {ref_valid, pins_s.sel, pins_s.cal_done, ~pins_s.holdover,
                      pins_s.synth_lock, pins_s.vcxo_lock, pins_s.in1_act, pins_s.in0_act};

    // Fault conditions feeding the sticky bits; the flag holds the fault.
    logic [`SICC_STICKY_W-1:0] cond;
    logic [`SICC_STICKY_W-1:0] clr;
    logic [`SICC_STICKY_W-1:0] fault;

    assign cond = {~ref_valid, pins_s.holdover, ~pins_s.synth_lock, ~pins_s.vcxo_lock,
                   ~pins_s.in1_act, ~pins_s.in0_act};
    assign clr  = (wr_byte && wb_adr_i == `SICC_ADDR_STICKY)
                ? wb_dat_i[`SICC_STICKY_W-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < `SICC_STICKY_W; gi = gi + 1) begin : g_sticky
            logic next_fault;
            always_comb begin
                next_fault = cond[gi] | (fault[gi] & ~clr[gi]);
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    fault[gi] <= 1'b0;
                end else begin
                    fault[gi] <= next_fault;
                end
            end
        end
    endgenerate

    // Software registers.
    logic [`SICC_STICKY_W-1:0] irq_en;
    logic [`SICC_STICKY_W-1:0] next_irq_en;
    sicc_ctrl_t                ctrl;
    sicc_ctrl_t                next_ctrl;

    always_comb begin
        next_irq_en = irq_en;
        next_ctrl   = ctrl;
        next_ctrl.init   = 1'b0;
        next_ctrl.pll_trigger_a = 1'b0;
        next_ctrl.cal    = 1'b0;
        if (wr_byte && wb_adr_i == `SICC_ADDR_IRQ_EN) begin
            next_irq_en = wb_dat_i[`SICC_STICKY_W-1:0];
        end
        if (wr_byte && wb_adr_i == `SICC_ADDR_CTRL) begin
            next_ctrl.init         = wb_dat_i[`SICC_CTRL_INIT];
            next_ctrl.pll_trigger_a       = wb_dat_i[`SICC_CTRL_PLL_TRIGGER_A];
            next_ctrl.cal          = wb_dat_i[`SICC_CTRL_CAL];
            next_ctrl.force_center = wb_dat_i[`SICC_CTRL_FORCE];
            next_ctrl.bank_en      = wb_dat_i[`SICC_CTRL_BANK];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en <= `SICC_IRQ_EN_RST;
            ctrl   <= `SICC_CTRL_RST;
        end else begin
            irq_en <= next_irq_en;
            ctrl   <= next_ctrl;
        end
    end

    assign ctrl_o = ctrl;

    // Wishbone answer: ack one cycle after the request, read data taken at that edge.
    logic        next_ack;
    logic [31:0] next_dat;

    always_comb begin
        next_ack = req & ~wb_ack_o;
        next_dat = '0;
        if (req && !wb_ack_o && !wb_we_i) begin
            case (wb_adr_i)
                `SICC_ADDR_NOW: begin
                    next_dat[`SICC_NOW_W-1:0] = now_vec;
                end
                `SICC_ADDR_STICKY: begin
                    next_dat[`SICC_STICKY_W-1:0] = ~fault;
                end
                `SICC_ADDR_IRQ_EN: begin
                    next_dat[`SICC_STICKY_W-1:0] = irq_en;
                end
                `SICC_ADDR_CTRL: begin
                    next_dat[$bits(sicc_ctrl_t)-1:0] = ctrl;
                end
                default: begin
                    next_dat = '0;
                end
            endcase
        end
    end

    // Interrupt and lock outputs.
    logic next_irq_n;
    logic next_lock;

    always_comb begin
        next_irq_n = ~|(fault & irq_en);
        next_lock  = ~fault[`SICC_STK_VCXO] & ~fault[`SICC_STK_SYNTH];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= '0;
            irq_out_n_o <= 1'b1;
            lock_o      <= 1'b0;
        end else begin
            wb_ack_o    <= next_ack;
            wb_dat_o    <= next_dat;
            irq_out_n_o <= next_irq_n;
            lock_o      <= next_lock;
        end
    end

    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_status_read: assert property (
        req && wb_ack_o && !wb_we_i && wb_adr_i == `SICC_ADDR_NOW && $past(req)
        |-> wb_dat_o[`SICC_NOW_W-1:0] == $past(now_vec))
        else $error("momentary read does not match status");

    chk_cal_not_latched: assert property (
        req && wb_ack_o && !wb_we_i && wb_adr_i == `SICC_ADDR_STICKY
        |-> wb_dat_o[31:`SICC_STICKY_W] == '0)
        else $error("sticky register shows unlatched bits");

    chk_sticky_holds: assert property (
        fault[`SICC_STK_IN0] && !clr[`SICC_STK_IN0] |=> fault[`SICC_STK_IN0])
        else $error("sticky bit lost without clear");

    chk_set_wins: assert property (
        cond[`SICC_STK_IN0] && clr[`SICC_STK_IN0] |=> fault[`SICC_STK_IN0])
        else $error("clear won over live condition");

    chk_irq_masked: assert property (
        irq_en == '0 |=> irq_out_n_o)
        else $error("interrupt with all enables off");

    chk_irq_assert: assert property (
        |(fault & irq_en) |=> !irq_out_n_o)
        else $error("interrupt not asserted");

    chk_irq_release: assert property (
        !(|(fault & irq_en)) ##1 !(|(fault & irq_en)) |-> irq_out_n_o)
        else $error("interrupt not released");

    chk_auto_ref: assert property (
        pins_s.mode == SICC_MODE_AUTO && pins_s.selecting |-> !now_vec[`SICC_NOW_REF])
        else $error("reference valid during selection");

    chk_lock_out: assert property (
        fault[`SICC_STK_VCXO] || fault[`SICC_STK_SYNTH] |=> !lock_o)
        else $error("lock output high while unlocked");

    chk_reset_vals: assert property (
        $past(rst_i) |-> ctrl.force_center && !ctrl.bank_en && irq_en == '0)
        else $error("register defaults wrong after reset");

    chk_force_hold: assert property (
        ctrl.force_center && !(wr_byte && wb_adr_i == `SICC_ADDR_CTRL) |=> ctrl.force_center)
        else $error("force bit dropped without write");

    chk_trig_clear: assert property (
        ctrl.init || ctrl.pll_trigger_a || ctrl.cal |=> !(ctrl.init || ctrl.pll_trigger_a || ctrl.cal)
            || $past(wr_byte))
        else $error("trigger bit did not self-clear");

    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // The low five live bits sit at the same positions as their sticky copies.
    chk_in0_polarity: assert property (
        !pins_s.in0_act |-> !now_vec[`SICC_STK_IN0])
        else $error("input 0 bit reads active while lost");

    chk_in1_polarity: assert property (
        !pins_s.in1_act |-> !now_vec[`SICC_STK_IN1])
        else $error("input 1 bit reads active while lost");

    chk_vcxo_polarity: assert property (
        !pins_s.vcxo_lock |-> !now_vec[`SICC_STK_VCXO])
        else $error("vcxo lock bit reads locked while unlocked");

    chk_synth_polarity: assert property (
        !pins_s.synth_lock |-> !now_vec[`SICC_STK_SYNTH])
        else $error("synth lock bit reads locked while unlocked");

    chk_hold_polarity: assert property (
        pins_s.holdover |-> !now_vec[`SICC_STK_HOLD])
        else $error("holdover bit does not read 0 in holdover");

    chk_cal_live: assert property (
        pins_s.cal_done |-> now_vec[`SICC_NOW_CAL])
        else $error("calibration done not shown");

    chk_sel_live: assert property (
        pins_s.sel |-> now_vec[`SICC_NOW_SEL])
        else $error("selected input not shown");

    chk_man_ref_lost: assert property (
        pins_s.mode == SICC_MODE_MANUAL && !sel_act |-> !now_vec[`SICC_NOW_REF])
        else $error("manual mode reference valid while lost");

    chk_man_ref_ok: assert property (
        pins_s.mode == SICC_MODE_MANUAL && sel_act |-> now_vec[`SICC_NOW_REF])
        else $error("manual mode reference invalid while present");

    chk_man_hold_ref: assert property (
        pins_s.mode == SICC_MODE_MAN_HOLD && man_chg && pins_s.holdover
        |-> !now_vec[`SICC_NOW_REF])
        else $error("reference valid after change in holdover");

    chk_auto_hold_ref: assert property (
        pins_s.mode == SICC_MODE_AUTO_HOLD && !sel_act && pins_s.holdover
        |-> !now_vec[`SICC_NOW_REF])
        else $error("reference valid while lost in holdover");

    chk_sticky_set: assert property (
        cond[`SICC_STK_REF] |=> fault[`SICC_STK_REF])
        else $error("sticky bit not set by condition");

    chk_clear_works: assert property (
        fault[`SICC_STK_IN0] && clr[`SICC_STK_IN0] && !cond[`SICC_STK_IN0]
        |=> !fault[`SICC_STK_IN0])
        else $error("sticky bit not cleared by write");

    chk_lock_high: assert property (
        !fault[`SICC_STK_VCXO] && !fault[`SICC_STK_SYNTH] |=> lock_o)
        else $error("lock output low while both locked");

    chk_bank_hold: assert property (
        !ctrl.bank_en && !(wr_byte && wb_adr_i == `SICC_ADDR_CTRL) |=> !ctrl.bank_en)
        else $error("bank outputs enabled without write");

    chk_init_pulse: assert property (
        ctrl.init |=> !ctrl.init)
        else $error("init bit did not self-clear");

    chk_pll_trigger_a_pulse: assert property (
        ctrl.pll_trigger_a |=> !ctrl.pll_trigger_a)
        else $error("pll_trigger_a bit did not self-clear");

    chk_cal_pulse: assert property (
        ctrl.cal |=> !ctrl.cal)
        else $error("calibration bit did not self-clear");

    chk_ack_answer: assert property (
        req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");

    chk_dat_idle: assert property (
        !wb_ack_o |-> wb_dat_o == '0)
        else $error("read data shown outside acknowledge");
endmodule

//--- tb/sicc_tb.sv
// Self-checking bench for the status, interrupt and startup block.
`timescale 1ns/1ps
`include "sicc_consts.svh"

module testbench;
    import sicc_pkg::*;
    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        cyc         = 1'b0;
    logic        we          = 1'b0;
    logic [7:0]  adr         = 8'h00;
    logic [3:0]  sel         = 4'h0;
    logic [31:0] dat         = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] q;
    logic        ack;
    logic        irq_n;
    logic        lock;
    sicc_pins_t  pins        = 10'h000;
    sicc_ctrl_t  ctrl;
    int          miscompares = 0;
    int          check_count = 0;
    int          cycles      = 0;
    int          n_init      = 0;
    int          n_pll_trigger_a    = 0;
    int          n_cal       = 0;
    // Pin patterns and the live status byte each one must produce.
    logic [9:0]  mp [11] = '{10'h3d0, 10'h1d0, 10'h1d8, 10'h3c0, 10'h3d5, 10'h1d1,
                            10'h3f3, 10'h1f3, 10'h3f2, 10'h3fa, 10'h3da};
    logic [7:0]  me [11] = '{8'hbf, 8'h3e, 8'hfe, 8'h9f, 8'h3f, 8'h3e,
                            8'h2f, 8'h2e, 8'haf, 8'h6f, 8'hff};

    always #25 clk_i = ~clk_i;

    sicc_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .pins_i(pins), .ctrl_o(ctrl), .irq_out_n_o(irq_n), .lock_o(lock)
    );

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            miscompares++;
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) begin
            chk("ack_wait", 32'h1, 32'h0);
        end
        cyc <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0, 4'hf);
        chk(nm, e, q);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Counts trigger pulses and cuts a hang short.
    always @(posedge clk_i) begin
        cycles++;
        if (ctrl.init === 1'b1) n_init++;
        if (ctrl.pll_trigger_a === 1'b1) n_pll_trigger_a++;
        if (ctrl.cal === 1'b1) n_cal++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        wt(20);
        rst_i <= 1'b0;
        pins  <= 10'h3d0;
        chk("ctrl_o", 32'h08, {27'h0, ctrl});
        chk("irq_n", 32'h1, {31'h0, irq_n});
        rd(`SICC_ADDR_CTRL, 32'h08, "ctrl");
        rd(`SICC_ADDR_IRQ_EN, 32'h0, "irq_en");
        rd(8'h10, 32'h0, "unmapped");
        xfer(1'b1, `SICC_ADDR_IRQ_EN, 32'h3f, 4'he);
        rd(`SICC_ADDR_IRQ_EN, 32'h0, "irq_en_nosel");
        wt(6);
        wr(`SICC_ADDR_STICKY, 32'h3f);
        wr(`SICC_ADDR_NOW, 32'h00);
        rd(`SICC_ADDR_NOW, 32'hbf, "now_ro");
        rd(`SICC_ADDR_STICKY, 32'h3f, "sticky_clear");
        chk("lock", 32'h1, {31'h0, lock});
        $display("Test reset done");
        wr(`SICC_ADDR_IRQ_EN, 32'h01);
        pins <= 10'h2d0;
        wt(6);
        chk("irq_masked", 32'h1, {31'h0, irq_n});
        pins <= 10'h0d0;
        wt(6);
        chk("irq_on", 32'h0, {31'h0, irq_n});
        pins <= 10'h3d0;
        wt(6);
        chk("irq_held", 32'h0, {31'h0, irq_n});
        wr(`SICC_ADDR_STICKY, 32'h01);
        wt(3);
        chk("irq_off", 32'h1, {31'h0, irq_n});
        rd(`SICC_ADDR_STICKY, 32'h1d, "sticky_part");
        wr(`SICC_ADDR_IRQ_EN, 32'h03);
        wt(3);
        chk("irq_unmask", 32'h0, {31'h0, irq_n});
        wr(`SICC_ADDR_STICKY, 32'h3f);
        wt(3);
        chk("irq_done", 32'h1, {31'h0, irq_n});
        $display("Test interrupt done");
        pins <= 10'h350;
        wt(6);
        chk("lock_lost", 32'h0, {31'h0, lock});
        pins <= 10'h3d0;
        wt(6);
        chk("lock_sticky", 32'h0, {31'h0, lock});
        rd(`SICC_ADDR_STICKY, 32'h3b, "sticky_vcxo");
        wr(`SICC_ADDR_STICKY, 32'h3f);
        wt(3);
        chk("lock_back", 32'h1, {31'h0, lock});
        pins <= 10'h390;
        wt(6);
        chk("lock_synth", 32'h0, {31'h0, lock});
        pins <= 10'h3d0;
        wt(6);
        wr(`SICC_ADDR_STICKY, 32'h3f);
        wt(3);
        chk("lock_again", 32'h1, {31'h0, lock});
        pins <= 10'h1d0;
        wt(6);
        wr(`SICC_ADDR_STICKY, 32'h3f);
        wt(3);
        rd(`SICC_ADDR_STICKY, 32'h1e, "sticky_live");
        pins <= 10'h3d0;
        wt(6);
        wr(`SICC_ADDR_STICKY, 32'h3f);
        rd(`SICC_ADDR_STICKY, 32'h3f, "sticky_gone");
        $display("Test sticky done");
        for (int i = 0; i < 11; i++) begin
            pins <= mp[i];
            wt(6);
            rd(`SICC_ADDR_NOW, {24'h0, me[i]}, "now_mode");
        end
        rd(`SICC_ADDR_STICKY, 32'h0e, "sticky_modes");
        chk("irq_modes", 32'h0, {31'h0, irq_n});
        $display("Test modes done");
        wr(`SICC_ADDR_CTRL, 32'h09);
        wt(3);
        chk("init_pulses", 32'h1, n_init);
        chk("pll_trigger_a_early", 32'h0, n_pll_trigger_a);
        rd(`SICC_ADDR_CTRL, 32'h08, "init_clear");
        wr(`SICC_ADDR_CTRL, 32'h0e);
        wt(3);
        chk("pll_trigger_a_pulses", 32'h1, n_pll_trigger_a);
        chk("cal_pulses", 32'h1, n_cal);
        rd(`SICC_ADDR_CTRL, 32'h08, "trig_clear");
        wr(`SICC_ADDR_CTRL, 32'h00);
        wt(2);
        chk("ctrl_free", 32'h00, {27'h0, ctrl});
        wr(`SICC_ADDR_STICKY, 32'h3f);
        wt(3);
        chk("irq_clear", 32'h1, {31'h0, irq_n});
        wr(`SICC_ADDR_CTRL, 32'h10);
        wt(2);
        chk("ctrl_bank", 32'h10, {27'h0, ctrl});
        rd(`SICC_ADDR_CTRL, 32'h10, "ctrl_rd");
        $display("Test startup done");
        rst_i <= 1'b1;
        wt(3);
        rst_i <= 1'b0;
        chk("ctrl_reset", 32'h08, {27'h0, ctrl});
        rd(`SICC_ADDR_IRQ_EN, 32'h0, "irq_en_reset");
        $display("Test reset again done");
        summarize();
    end
endmodule
